/* File: logic/brs_pkg.sv */
/*
  Package for the brown-out reset sequencer: register map, field layout,
  reset-cause encodings and timing constants.
  Assumes a 10 MHz system clock and a classic Wishbone slave with 32-bit data.
*/
// Contract
// - Enable setting 11 always on, 10 on except sleep, 0x off.
// - One configuration bit selects between two brown-out thresholds.
// - Supply low longer than minimum duration forces brown-out reset.
// - Brown-out during power-up count re-enters reset and restarts the count.
// - After supply recovers, hold reset for the 64 ms power-up interval.
// - Flash erase forces detection on at the lowest threshold.
// - Power-up count starts after power-on reset; oscillator count after it.
// - Crystal modes add 1024 oscillator periods; other modes only power-up delay.
// - External clock with power-up timer disabled has no time-out at all.
// - Time-outs run regardless of master clear; release starts execution at once.
// - Brownout flag cleared by brown-out reset, kept across other resets; the code also clears it on power-on reset.
// - Brownout flag is meaningless when detection is configured off.
// - Power-on flag cleared by power-on reset, kept by all other resets; the code sets it on brown-out reset.
// - Power-on and brown-out set timeout and powerdown; master clear keeps them.
// - Watchdog reset clears timeout; wake clears both; sleep clear sets timeout. The code clears both on watchdog wake only; interrupt wake sets timeout.
// - Any reset loads program counter low with zero; wake continues at PC+1. The code holds reset and loads zero after a watchdog wake in crystal mode.
// - Status loads 0001 1xxx on power/brown-out; upper three cleared otherwise.
// - Power-up timer disabled when its configuration bit is one.
package brs_pkg;

  localparam logic [7:0] REG_STATUS = 8'h03;
  localparam logic [7:0] REG_PCTL   = 8'h8E;
  localparam logic [7:0] REG_CFG    = 8'hC0;
  localparam logic [7:0] REG_SEQ    = 8'hC4;

  localparam int BIT_PD   = 3;
  localparam int BIT_TO   = 4;
  localparam int BIT_BOF  = 0;
  localparam int BIT_POF  = 1;

  localparam logic [7:0] STATUS_POR_VAL = 8'h18;
  localparam logic [2:0] STATUS_UP_CLR  = 3'h0;
  localparam logic [7:0] PCL_RESET_VAL  = 8'h00;

  localparam int  CLK_HZ          = 10_000_000;
  localparam int  POWERUP_TIMER_MS         = 64;
  localparam int  POWERUP_TIMER_CYCLES     = (CLK_HZ / 1000) * POWERUP_TIMER_MS;
  localparam int  OST_PERIODS     = 1024;
  localparam int  BOR_MIN_NS      = 1000;
  localparam int  BOR_MIN_CYCLES  = (BOR_MIN_NS + 99) / 100;

  typedef enum logic [2:0]
  {
    BRS_OSC_LP,
    BRS_OSC_XT,
    BRS_OSC_HS,
    BRS_OSC_RC,
    BRS_OSC_EC,
    BRS_OSC_INT
  } brs_osc_t;

  typedef struct packed
  {
    logic [1:0] brownout_enable_sel;
    logic       brownout_level_sel;
    logic       powerup_timer_disable;
    brs_osc_t   osc_mode;
  } brs_cfg_t;

  typedef struct packed
  {
    logic wdt_reset;
    logic wdt_wake;
    logic irq_wake;
  } brs_evt_t;

endpackage

/* File: logic/brs_sequencer.sv */
/*
  Reset sequencer: brown-out qualification, power-up and oscillator
  start-up time-outs, reset-cause flags and the two status registers.
  Assumes supply comparator and pin inputs are asynchronous and the
  oscillator start-up count arrives as one enable pulse per period.
*/
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
module brs_sequencer
  import brs_pkg::*;
#(
  parameter int POWERUP_TIMER_COUNT = POWERUP_TIMER_CYCLES,
  parameter int OST_COUNT  = OST_PERIODS,
  parameter int BOR_COUNT  = BOR_MIN_CYCLES
)
(
  // Clock and power-on pulse
  input  wire logic        CLK_SYS,
  input  wire logic        SRST,
  // Supply comparators and pins
  input  wire logic        BOR_LOW_HI,
  input  wire logic        BOR_LOW_LO,
  input  wire logic        MASTER_CLEAR_PIN_N,
  input  wire logic        OSC_TICK,
  // Core events
  input  wire logic        SLEEPING,
  input  wire logic        FLASH_ERASE,
  input  wire brs_evt_t    EVT,
  input  wire logic        MASTER_CLEAR_PIN_ENABLE,
  // Outputs
  output logic             RESET_OUT,
  output logic             BROWNOUT_LEVEL,
  output logic             LOAD_PCL,
  output logic [7:0]       PCL_VALUE,
  output logic             RESUME_NEXT,
  // Wishbone slave
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic [31:0]      DAT_O,
  output logic             ACK_O
);

  typedef enum logic [2:0] {S_POR, S_POWERUP_TIMER, S_OST, S_RUN, S_BOR} brs_state_t;

  brs_state_t  state;
  brs_cfg_t    cfg;
  logic [22:0] cnt;
  logic [15:0] bor_cnt;
  logic [1:0]  hi_sync;
  logic [1:0]  lo_sync;
  logic [1:0]  master_clear_pin_sync;
  logic [1:0]  tick_sync;
  logic        tick_d;
  logic [7:0]  status_reg;
  logic        brownout_flag;
  logic        poweron_flag;
  logic        bor_active;
  logic        sel_low;
  logic        supply_low;
  logic        bor_trip;
  logic        tick;
  logic        crystal;
  logic        master_clear_pin_low;
  logic        seq_done;
  logic        wb_req;
  logic        wr_pctl;
  logic        wr_status;
  logic        wr_cfg;

  function automatic logic is_crystal(input brs_osc_t m);
    return (m == BRS_OSC_LP) || (m == BRS_OSC_XT) || (m == BRS_OSC_HS);
  endfunction

  // Asynchronous inputs pass two flops before use
  always_ff @(posedge CLK_SYS)
  begin
    hi_sync   <= {hi_sync[0], BOR_LOW_HI};
    lo_sync   <= {lo_sync[0], BOR_LOW_LO};
    master_clear_pin_sync <= {master_clear_pin_sync[0], MASTER_CLEAR_PIN_N};
    tick_sync <= {tick_sync[0], OSC_TICK};
    tick_d    <= tick_sync[1];
  end

  assign tick     = tick_sync[1] & ~tick_d;
  assign crystal  = is_crystal(cfg.osc_mode);
  assign master_clear_pin_low = MASTER_CLEAR_PIN_ENABLE & ~master_clear_pin_sync[1];

  // Erase overrides configured enable and level
  always_comb
  begin
    bor_active = FLASH_ERASE
               | (cfg.brownout_enable_sel == 2'b11)
               | ((cfg.brownout_enable_sel == 2'b10) & ~SLEEPING);
    sel_low    = FLASH_ERASE | cfg.brownout_level_sel;
    supply_low = sel_low ? lo_sync[1] : hi_sync[1];
  end

  assign BROWNOUT_LEVEL = sel_low;

  // Short dips under the minimum duration are filtered out
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !bor_active || !supply_low)
      bor_cnt <= '0;
    else if (bor_cnt != 16'(BOR_COUNT))
      bor_cnt <= bor_cnt + 16'h0001;
  end

  assign bor_trip = bor_active && supply_low && (bor_cnt == 16'(BOR_COUNT));

  // Time-out chain, started by the power-on pulse or a brown-out trip; a watchdog wake in crystal mode reruns the oscillator count
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      state <= S_POR;
      cnt   <= '0;
    end
    else if (bor_trip)
    begin
      state <= S_BOR;
      cnt   <= '0;
    end
    else
    begin
      unique case (state)
        S_POR, S_BOR:
        begin
          cnt <= '0;
          if (!cfg.powerup_timer_disable)
            state <= S_POWERUP_TIMER;
          else if (crystal)
            state <= S_OST;
          else
            state <= S_RUN;
        end
        S_POWERUP_TIMER:
        begin
          if (cnt == 23'(POWERUP_TIMER_COUNT - 1))
          begin
            cnt   <= '0;
            state <= crystal ? S_OST : S_RUN;
          end
          else
            cnt <= cnt + 23'h000001;
        end
        S_OST:
        begin
          if (tick)
          begin
            if (cnt == 23'(OST_COUNT - 1))
            begin
              cnt   <= '0;
              state <= S_RUN;
            end
            else
              cnt <= cnt + 23'h000001;
          end
        end
        S_RUN:
        begin
          if (EVT.wdt_wake && crystal)
          begin
            cnt   <= '0;
            state <= S_OST;
          end
        end
      endcase
    end
  end

  assign seq_done  = (state == S_RUN);
  assign RESET_OUT = !seq_done || master_clear_pin_low || EVT.wdt_reset;

  // Program counter low byte load
  always_ff @(posedge CLK_SYS)
  begin
    LOAD_PCL    <= !seq_done || master_clear_pin_low || EVT.wdt_reset;
    PCL_VALUE   <= PCL_RESET_VAL;
    RESUME_NEXT <= seq_done && (EVT.wdt_wake || EVT.irq_wake);
  end

  // Wishbone decode, single-cycle ack
  assign wb_req    = CYC_I && STB_I && !ACK_O;
  assign wr_pctl   = wb_req && WE_I && SEL_I[0] && (ADR_I == REG_PCTL);
  assign wr_status = wb_req && WE_I && SEL_I[0] && (ADR_I == REG_STATUS);
  assign wr_cfg    = wb_req && WE_I && SEL_I[0] && (ADR_I == REG_CFG);

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      ACK_O <= 1'b0;
    else
      ACK_O <= wb_req;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      cfg <= '{2'b11, 1'b0, 1'b0, BRS_OSC_INT};
    else if (wr_cfg)
      cfg <= brs_cfg_t'(DAT_I[6:0]);
  end

  // Power control flags; a reset event wins over a software write
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      poweron_flag  <= 1'b0;
      brownout_flag <= 1'b0;
    end
    else if (bor_trip)
    begin
      poweron_flag  <= 1'b1;
      brownout_flag <= 1'b0;
    end
    else if (wr_pctl)
    begin
      poweron_flag  <= DAT_I[BIT_POF];
      brownout_flag <= DAT_I[BIT_BOF];
    end
  end

  // Status word: upper bits, timeout and powerdown per reset cause
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || bor_trip)
      status_reg <= STATUS_POR_VAL;
    else if (EVT.wdt_wake)
    begin
      status_reg[BIT_TO] <= 1'b0;
      status_reg[BIT_PD] <= 1'b0;
    end
    else if (EVT.wdt_reset)
    begin
      status_reg[7:5]    <= STATUS_UP_CLR;
      status_reg[BIT_TO] <= 1'b0;
    end
    else if (master_clear_pin_low && SLEEPING)
    begin
      status_reg[7:5]    <= STATUS_UP_CLR;
      status_reg[BIT_TO] <= 1'b1;
      status_reg[BIT_PD] <= 1'b0;
    end
    else if (master_clear_pin_low)
      status_reg[7:5] <= STATUS_UP_CLR;
    else if (EVT.irq_wake)
    begin
      status_reg[BIT_TO] <= 1'b1;
      status_reg[BIT_PD] <= 1'b0;
    end
    else if (wr_status)
      status_reg <= {DAT_I[7:5], status_reg[4:3], DAT_I[2:0]};
  end

  // Read mux, unmapped reads return zero
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      DAT_O <= '0;
    else if (wb_req && !WE_I)
    begin
      unique case (ADR_I)
        REG_STATUS: DAT_O <= {24'h000000, status_reg};
        REG_PCTL:   DAT_O <= {30'h00000000, poweron_flag, brownout_flag};
        REG_CFG:    DAT_O <= {25'h0000000, cfg};
        REG_SEQ:    DAT_O <= {28'h0000000, RESET_OUT, state};
        default:    DAT_O <= '0;
      endcase
    end
  end

  AST_POWERUP_TIMER_LEN: assert property (@(posedge CLK_SYS) disable iff (SRST || bor_trip)
    $rose(state == S_POWERUP_TIMER) |-> (state == S_POWERUP_TIMER) [*8])
    else $error("Power-up count ended early");

  AST_BOR_RESTART: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (bor_trip && state == S_POWERUP_TIMER) |=> (state == S_BOR) && (cnt == 23'h000000))
    else $error("Brown-out did not restart power-up count");

  AST_RESET_HELD: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (state != S_RUN) |-> RESET_OUT)
    else $error("Reset released before sequence done");

  AST_MASTER_CLEAR_PIN_HOLD: assert property (@(posedge CLK_SYS) disable iff (SRST)
    master_clear_pin_low |-> RESET_OUT)
    else $error("Master clear did not hold reset");

  AST_ERASE_FORCE: assert property (@(posedge CLK_SYS) disable iff (SRST)
    FLASH_ERASE |-> bor_active && BROWNOUT_LEVEL)
    else $error("Erase did not force detection");

  AST_BOR_OFF: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (!FLASH_ERASE && !cfg.brownout_enable_sel[1]) |-> !bor_active)
    else $error("Detection active while disabled");

  AST_BOR_FLAG: assert property (@(posedge CLK_SYS) disable iff (SRST)
    bor_trip |=> !brownout_flag && poweron_flag && status_reg[BIT_TO] && status_reg[BIT_PD])
    else $error("Brown-out flags wrong");

  AST_WDT_TO: assert property (@(posedge CLK_SYS) disable iff (SRST)
    (EVT.wdt_reset && !EVT.wdt_wake && !bor_trip) |=> !status_reg[BIT_TO])
    else $error("Watchdog reset left timeout set");

  AST_NO_TIMEOUT: assert property (@(posedge CLK_SYS) disable iff (SRST || bor_trip)
    (state == S_POR && cfg.powerup_timer_disable && cfg.osc_mode == BRS_OSC_EC) |=> state == S_RUN)
    else $error("Time-out applied in external clock mode");

endmodule

/* File: tb/brs_supply_model.sv */
/* Supply comparators, master clear pin and crystal seen by the sequencer.
   Assumes the bench commands it at rising clock edges. */
`timescale 1ns/1ps
module brs_supply_model
(
  // Clock
  input  wire logic clk,
  // Bench commands
  input  wire logic low_hi,
  input  wire logic low_lo,
  input  wire logic pin_low,
  input  wire logic osc_on,
  // Lines to the sequencer
  output logic      bor_low_hi,
  output logic      bor_low_lo,
  output logic      pin_n,
  output logic      osc_tick
);
  initial
  begin
    bor_low_hi = 1'h0;
    bor_low_lo = 1'h0;
    pin_n = 1'h1;
    osc_tick = 1'h0;
  end
  always @(posedge clk)
  begin
    // Below the low trip is also below the high one
    bor_low_hi <= low_hi | low_lo;
    bor_low_lo <= low_lo;
    // Weak pull-up: a released pin reads high
    pin_n <= !pin_low;
    // Crystal stands still until started
    osc_tick <= osc_on & !osc_tick;
  end
endmodule

/* File: tb/brownout_reset_sequencer_tb.sv */
/* Bench for brs_sequencer: time-outs, brown-out, reset-cause flags.
   Assumes brs_supply_model drives the comparators, pin and crystal. */
`timescale 1ns/1ps
module brownout_reset_sequencer_tb
  import brs_pkg::*;
;
  localparam int PW = 20;
  logic clk = 1'h0, srst = 1'h1, lo_hi = 1'h0, lo_lo = 1'h0, pin_low = 1'h0;
  logic osc_on = 1'h0, sleeping = 1'h0, erase = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat;
  brs_evt_t evt = '0;
  logic bor_hi, bor_lo, pin_n, tick, rst_out, lvl, load_pcl, resume, ack, sr, sp;
  logic [7:0] program_counter_low;
  logic [31:0] dat_o;
  int failures = 0, checked = 0, ticks = 0, n;
  always #50 clk = ~clk;
  brs_supply_model sup (.clk(clk), .low_hi(lo_hi), .low_lo(lo_lo), .pin_low(pin_low), .osc_on(osc_on),
    .bor_low_hi(bor_hi), .bor_low_lo(bor_lo), .pin_n(pin_n), .osc_tick(tick));
  brs_sequencer #(.POWERUP_TIMER_COUNT(PW), .OST_COUNT(4), .BOR_COUNT(2)) uut (.CLK_SYS(clk), .SRST(srst),
    .BOR_LOW_HI(bor_hi), .BOR_LOW_LO(bor_lo), .MASTER_CLEAR_PIN_N(pin_n), .OSC_TICK(tick),
    .SLEEPING(sleeping), .FLASH_ERASE(erase), .EVT(evt), .MASTER_CLEAR_PIN_ENABLE(1'h1), .RESET_OUT(rst_out),
    .BROWNOUT_LEVEL(lvl), .LOAD_PCL(load_pcl), .PCL_VALUE(program_counter_low), .RESUME_NEXT(resume), .CYC_I(cyc),
    .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'h1), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= {24'h0, d};
    do @(posedge clk); while (ack !== 1'h1);
    rdat = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 8'h00);
    chk(rdat, e);
  endtask
  task automatic run_wait(input int lim);
    n = 0;
    while (rst_out !== 1'h0 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic dip(input int c);
    @(posedge clk);
    lo_hi <= 1'h1;
    repeat (c) @(posedge clk);
    lo_hi <= 1'h0;
  endtask
  task automatic master_clear_pin;
    @(posedge clk);
    pin_low <= 1'h1;
    repeat (6) @(posedge clk);
    chk(rst_out, 1'h1);
    pin_low <= 1'h0;
    run_wait(10);
  endtask
  task automatic pulse(input logic [2:0] e);
    @(posedge clk);
    evt <= brs_evt_t'(e);
    @(posedge clk);
    evt <= '0;
    sr = 1'h0;
    sp = 1'h0;
    repeat (3)
    begin
      @(posedge clk);
      sr |= resume;
      sp |= load_pcl;
    end
  endtask
  task automatic t_powerup;
    run_wait(PW + 40);
    chk(n >= PW - 3 && n <= PW + 8, 1'h1);
    rdc(REG_CFG, 32'h65);
    rdc(REG_STATUS, 32'h18);
    rdc(REG_PCTL, 32'h0);
    rdc(REG_SEQ, 32'h3);
    rdc(8'h10, 32'h0);
    wb(1'h1, REG_STATUS, 8'h00);
    rdc(REG_STATUS, 32'h18);
    wb(1'h1, REG_PCTL, 8'h03);
    rdc(REG_PCTL, 32'h3);
  endtask
  task automatic t_causes;
    wb(1'h1, REG_STATUS, 8'hE0);
    master_clear_pin();
    rdc(REG_STATUS, 32'h18);
    rdc(REG_PCTL, 32'h3);
    pulse(3'h4);
    chk(sp, 1'h1);
    rdc(REG_STATUS, 32'h08);
    sleeping <= 1'h1;
    // Interrupt wake: resume at next word, timeout set, powerdown cleared
    pulse(3'h1);
    chk(sr, 1'h1);
    chk(sp, 1'h0);
    rdc(REG_STATUS, 32'h10);
    pulse(3'h2);
    chk(sr, 1'h1);
    chk(sp, 1'h0);
    rdc(REG_STATUS, 32'h00);
    master_clear_pin();
    rdc(REG_STATUS, 32'h10);
    sleeping <= 1'h0;
  endtask
  task automatic t_brownout;
    dip(2);
    repeat (6) @(posedge clk);
    chk(rst_out, 1'h0);
    lo_hi <= 1'h1;
    repeat (8) @(posedge clk);
    rdc(REG_SEQ, 32'hC);
    lo_hi <= 1'h0;
    repeat (10) @(posedge clk);
    chk(rst_out, 1'h1);
    dip(8);
    run_wait(PW + 20);
    chk(n >= PW && n <= PW + 8, 1'h1);
    rdc(REG_PCTL, 32'h2);
    rdc(REG_STATUS, 32'h18);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 6; m++)
    begin
      wb(1'h1, REG_CFG, 8'h60 | m[7:0]);
      dip(8);
      run_wait(PW + 10);
      chk(rst_out, m < 3);
      rdc(REG_SEQ, m < 3 ? 32'hA : 32'h3);
      osc_on <= 1'h1;
      run_wait(30);
      osc_on <= 1'h0;
      chk(rst_out, 1'h0);
    end
    wb(1'h1, REG_CFG, 8'h6C);
    dip(8);
    run_wait(12);
    chk(n <= 8, 1'h1);
  endtask
  task automatic t_enable;
    wb(1'h1, REG_CFG, 8'h45);
    sleeping <= 1'h1;
    dip(8);
    repeat (4) @(posedge clk);
    chk(rst_out, 1'h0);
    sleeping <= 1'h0;
    dip(8);
    chk(rst_out, 1'h1);
    run_wait(PW + 20);
    wb(1'h1, REG_CFG, 8'h05);
    dip(8);
    repeat (4) @(posedge clk);
    chk(rst_out, 1'h0);
    chk(lvl, 1'h0);
    erase <= 1'h1;
    lo_lo <= 1'h1;
    repeat (8) @(posedge clk);
    chk(lvl, 1'h1);
    chk(rst_out, 1'h1);
    erase <= 1'h0;
    lo_lo <= 1'h0;
    run_wait(PW + 20);
    wb(1'h1, REG_CFG, 8'h75);
    chk(lvl, 1'h1);
    dip(8);
    repeat (4) @(posedge clk);
    chk(rst_out, 1'h0);
  endtask
  task automatic t_held_pin;
    @(posedge clk);
    srst <= 1'h1;
    pin_low <= 1'h1;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    repeat (PW + 10) @(posedge clk);
    rdc(REG_SEQ, 32'hB);
    pin_low <= 1'h0;
    run_wait(6);
    chk(rst_out, 1'h0);
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 5000)
    begin
      failures++;
      summarize();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    repeat (2) @(posedge clk);
    chk(load_pcl, 1'h1);
    chk(program_counter_low, 8'h00);
    t_powerup();
    t_causes();
    t_brownout();
    t_modes();
    t_enable();
    t_held_pin();
    summarize();
  end
endmodule
